// [design/pdcc_pkg.sv]
package pdcc_pkg;
	// word indexes: printed offset 0xff3d is not a multiple of four, so 0xff3c/0xff3d are indexes
	localparam logic [15:0] IDX_HALT_HIGH   = 16'hFF3C;
	localparam logic [15:0] IDX_HALT_LOW    = 16'hFF3D;
	localparam logic [15:0] IDX_STANDBY     = 16'hFF3A;
	localparam logic [15:0] IDX_CLOCK       = 16'hFF3B;
	localparam logic [15:0] IDX_MODE        = 16'hFF3E;
	localparam logic [15:0] IDX_POWER_CMD   = 16'hFF3F;
	localparam logic [15:0] IDX_POWER_STAT  = 16'hFF40;

	// reset values
	localparam logic [7:0] RST_HALT_HIGH = 8'h3F;
	localparam logic [7:0] RST_HALT_LOW  = 8'hFF;
	localparam logic [7:0] RST_STANDBY   = 8'h08;
	localparam logic [7:0] RST_CLOCK     = 8'h00;
	localparam logic [4:0] MODE_UPPER    = 5'h10;

	// standby_control fields
	localparam int STB_DEEP   = 7;
	localparam int STB_WAIT_H = 6;
	localparam int STB_WAIT_L = 4;
	localparam int STB_KEEP   = 3;
	localparam int STB_WAKE   = 0;
	localparam logic [7:0] STB_WMASK = 8'hF9;

	// system_clock_control fields
	localparam int CLK_HALT  = 7;
	localparam int CLK_SCOPE = 5;
	localparam logic [7:0] CLK_WMASK = 8'hA7;

	// power command bits
	localparam int CMD_SLEEP = 0;

	// wait counts in states
	localparam int WAIT_0 = 8192;
	localparam int WAIT_5 = 262144;
	localparam int WAIT_7 = 16;

	typedef enum logic [1:0] {
		PDCC_RUN     = 2'b00,
		PDCC_SLEEP   = 2'b01,
		PDCC_STANDBY = 2'b11,
		PDCC_SETTLE  = 2'b10
	} pdcc_state_t;
endpackage

// [design/pdcc_top.sv]
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - standby bit picks sleep or deep standby
// - wait field picks standby exit settling states
// - keep bit holds or floats bus outputs
// - irq3-7 wake standby only when selected
// - scope 0: bus master clock divided
// - scope 1: whole chip clock divided
// - clock pin: clock, high, or floating
// - stop bits halt modules; reset 0x3fff
// - stop bits map onto named modules
// - mode status reads pins, bit7 one
module pdcc_top
	import pdcc_pkg::*;
#(
	parameter int WAIT_SHORT_DIV = 1
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        sleep_exec,
	input  wire logic [7:0]  irq_wake_n,
	input  wire logic        nmi_wake,
	input  wire logic        hw_standby,
	input  wire logic [2:0]  mode_pins,
	output logic             cpu_clock_en,
	output logic             chip_clock_en,
	output logic             clock_pin_o,
	output logic             clock_pin_oe,
	output logic             bus_out_oe,
	output logic             bus_out_hold,
	output logic             standby_active,
	output logic             sleep_active,
	output logic [15:0]      module_halt
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
		logic              aw_held;
		logic [15:0]       aw_idx;
		logic              w_held;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic [7:0]        stb;
		logic [7:0]        clk;
		logic [15:0]       halt;
		pdcc_state_t       st;
		logic [18:0]       wait_cnt;
		logic [4:0]        div_cnt;
		logic              cpu_en;
		logic              chip_en;
		logic              pin_o;
		logic              pin_oe;
		logic              bus_oe;
		logic              bus_hold;
		logic              sby_out;
		logic              slp_out;
	} pdcc_regs_t;

	pdcc_regs_t s_r;
	pdcc_regs_t s_nxt;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [15:0] addr_idx(input logic [31:0] a);
		addr_idx = a[17:2];
	endfunction

	function automatic logic [18:0] wait_states(input logic [2:0] code);
		logic [18:0] w;
		w = 19'(WAIT_0);
		unique case (code)
			3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5: w = 19'(WAIT_0) << code;
			3'h7: w = 19'(WAIT_7);
			default: w = 19'(WAIT_5); // reserved code: take longest wait, safe for oscillator
		endcase
		wait_states = w / 19'(WAIT_SHORT_DIV);
	endfunction

	// divider mask: enable when low bits of counter all zero
	function automatic logic [4:0] div_mask(input logic [2:0] code);
		logic [4:0] m;
		m = 5'h00;
		unique case (code)
			3'h1: m = 5'h01;
			3'h2: m = 5'h03;
			3'h3: m = 5'h07;
			3'h4: m = 5'h0F;
			3'h5: m = 5'h1F;
			default: m = 5'h00;
		endcase
		div_mask = m;
	endfunction

	function automatic logic [7:0] apply_strb(input logic [7:0] old, input logic [7:0] nw,
			input logic [7:0] msk, input logic lane);
		apply_strb = lane ? ((old & ~msk) | (nw & msk)) : old;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next-state logic

	logic [7:0]  mode_rd;
	logic [31:0] rd_word;
	logic        rd_ok;
	logic        wr_ok;
	logic        wake;
	logic [2:0]  sel;
	logic [4:0]  mask;
	logic        tick;

	// mode readback: bit7 one, low bits follow pins
	assign mode_rd = {MODE_UPPER, mode_pins};

	always_comb begin
		s_nxt   = s_r;
		rd_ok   = 1'b1;
		rd_word = 32'h0000_0000;
		wr_ok   = 1'b1;

		// write address and data captured independently, in either order
		if (s_axi_awvalid && s_r.awready) begin
			s_nxt.aw_held = 1'b1;
			s_nxt.aw_idx  = addr_idx(s_axi_awaddr);
			s_nxt.awready = 1'b0;
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.w_held = 1'b1;
			s_nxt.wdata  = s_axi_wdata;
			s_nxt.wstrb  = s_axi_wstrb;
			s_nxt.wready = 1'b0;
		end

		// settling countdown; a late software sleep request is ignored meanwhile
		// irq3..7 only count when the wake select bit is set
		wake = nmi_wake || !(&irq_wake_n[2:0]) ||
			(s_r.stb[STB_WAKE] && !(&irq_wake_n[7:3]));

		unique case (s_r.st)
			PDCC_RUN: begin
				if (sleep_exec)
					s_nxt.st = s_r.stb[STB_DEEP] ? PDCC_STANDBY : PDCC_SLEEP;
			end
			PDCC_SLEEP: begin
				if (wake)
					s_nxt.st = PDCC_RUN;
			end
			PDCC_STANDBY: begin
				if (wake) begin
					s_nxt.st       = PDCC_SETTLE;
					s_nxt.wait_cnt = wait_states(s_r.stb[STB_WAIT_H:STB_WAIT_L]);
				end
			end
			PDCC_SETTLE: begin
				// resume only after the count expires
				if (s_r.wait_cnt <= 19'h00001)
					s_nxt.st = PDCC_RUN;
				else
					s_nxt.wait_cnt = s_r.wait_cnt - 19'h00001;
			end
		endcase

		// completed write: both halves held and no response pending
		if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
			unique case (s_r.aw_idx)
				IDX_STANDBY:   s_nxt.stb = apply_strb(s_r.stb, s_r.wdata[7:0], STB_WMASK, s_r.wstrb[0]);
				IDX_CLOCK:     s_nxt.clk = apply_strb(s_r.clk, s_r.wdata[7:0], CLK_WMASK, s_r.wstrb[0]);
				IDX_HALT_HIGH: s_nxt.halt[15:8] = apply_strb(s_r.halt[15:8], s_r.wdata[7:0], 8'hFF,
						s_r.wstrb[0]);
				IDX_HALT_LOW:  s_nxt.halt[7:0] = apply_strb(s_r.halt[7:0], s_r.wdata[7:0], 8'hFF,
						s_r.wstrb[0]);
				IDX_MODE: ;
				IDX_POWER_STAT: ;
				IDX_POWER_CMD: begin
					// software sleep command behaves as the instruction
					if (s_r.wstrb[0] && s_r.wdata[CMD_SLEEP] && s_r.st == PDCC_RUN)
						s_nxt.st = s_r.stb[STB_DEEP] ? PDCC_STANDBY : PDCC_SLEEP;
				end
				default: wr_ok = 1'b0;
			endcase
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = wr_ok ? 2'b00 : 2'b10;
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held  = 1'b0;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid  = 1'b0;
			s_nxt.awready = 1'b1;
			s_nxt.wready  = 1'b1;
		end

		// read channel: one outstanding read
		if (s_axi_arvalid && s_r.arready) begin
			unique case (addr_idx(s_axi_araddr))
				IDX_STANDBY:    rd_word = {24'h000000, s_r.stb};
				IDX_CLOCK:      rd_word = {24'h000000, s_r.clk};
				IDX_HALT_HIGH:  rd_word = {24'h000000, s_r.halt[15:8]};
				IDX_HALT_LOW:   rd_word = {24'h000000, s_r.halt[7:0]};
				IDX_MODE:       rd_word = {24'h000000, mode_rd};
				IDX_POWER_CMD:  rd_word = 32'h0000_0000;
				IDX_POWER_STAT: rd_word = {30'h0000_0000, s_r.st};
				default:        rd_ok   = 1'b0;
			endcase
			s_nxt.rdata   = rd_word;
			s_nxt.rresp   = rd_ok ? 2'b00 : 2'b10;
			s_nxt.rvalid  = 1'b1;
			s_nxt.arready = 1'b0;
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid  = 1'b0;
			s_nxt.arready = 1'b1;
		end

		// clock division; codes 1xx with chip scope are undefined, treated as full speed
		sel  = s_r.clk[2:0];
		mask = (s_r.clk[CLK_SCOPE] && sel[2]) ? 5'h00 : div_mask(sel);
		s_nxt.div_cnt = s_r.div_cnt + 5'h01;
		tick = ((s_r.div_cnt & mask) == 5'h00);
		if (s_nxt.st != PDCC_RUN) begin
			// internal clocks stop in standby and during settling; cpu stops in sleep
			s_nxt.cpu_en  = 1'b0;
			s_nxt.chip_en = (s_nxt.st == PDCC_SLEEP);
		end else if (s_r.clk[CLK_SCOPE]) begin
			s_nxt.cpu_en  = tick;
			s_nxt.chip_en = tick;
		end else begin
			s_nxt.cpu_en  = tick;
			s_nxt.chip_en = 1'b1;
		end

		// clock pin: follows clock unless halted or in standby; floats in hardware standby
		s_nxt.pin_oe = !hw_standby;
		s_nxt.pin_o  = s_r.clk[CLK_HALT] || s_nxt.st == PDCC_STANDBY || s_nxt.st == PDCC_SETTLE ||
			!s_r.pin_o;

		// bus outputs in standby: hold or float
		if (hw_standby) begin
			s_nxt.bus_oe   = 1'b0;
			s_nxt.bus_hold = 1'b0;
		end else if (s_nxt.st == PDCC_STANDBY || s_nxt.st == PDCC_SETTLE) begin
			s_nxt.bus_oe   = s_r.stb[STB_KEEP];
			s_nxt.bus_hold = s_r.stb[STB_KEEP];
		end else begin
			s_nxt.bus_oe   = 1'b1;
			s_nxt.bus_hold = 1'b0;
		end

		// mode flags registered with the state so the outputs come from flops
		s_nxt.sby_out = (s_nxt.st == PDCC_STANDBY) || (s_nxt.st == PDCC_SETTLE);
		s_nxt.slp_out = (s_nxt.st == PDCC_SLEEP);
	end

	////////////////////////////////////////////////////////////////////////
	// register update

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r          <= '0;
			s_r.awready  <= 1'b1;
			s_r.wready   <= 1'b1;
			s_r.arready  <= 1'b1;
			s_r.stb      <= RST_STANDBY;
			s_r.clk      <= RST_CLOCK;
			// dma and transfer controller run, others stopped
			s_r.halt     <= {RST_HALT_HIGH, RST_HALT_LOW};
			s_r.st       <= PDCC_RUN;
			s_r.pin_o    <= 1'b1;
			s_r.pin_oe   <= 1'b1;
			s_r.bus_oe   <= 1'b1;
			s_r.cpu_en   <= 1'b1;
			s_r.chip_en  <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from flops
	assign s_axi_awready  = s_r.awready;
	assign s_axi_wready   = s_r.wready;
	assign s_axi_bvalid   = s_r.bvalid;
	assign s_axi_bresp    = s_r.bresp;
	assign s_axi_arready  = s_r.arready;
	assign s_axi_rvalid   = s_r.rvalid;
	assign s_axi_rresp    = s_r.rresp;
	assign s_axi_rdata    = s_r.rdata;
	assign cpu_clock_en   = s_r.cpu_en;
	assign chip_clock_en  = s_r.chip_en;
	assign clock_pin_o    = s_r.pin_o;
	assign clock_pin_oe   = s_r.pin_oe;
	assign bus_out_oe     = s_r.bus_oe;
	assign bus_out_hold   = s_r.bus_hold;
	assign standby_active = s_r.sby_out;
	assign sleep_active   = s_r.slp_out;
	// bit15 mover, 14 transfer, 13 pulse timer ... 7-5 serial 2-0, 4 converters 2/3
	assign module_halt    = s_r.halt;

endmodule // pdcc_top

// [verification/pdcc_props.sv]
`timescale 1ns/1ps
// port-level checks for the power-down block
module pdcc_props (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        hw_standby,
	input wire logic        clock_pin_o,
	input wire logic        clock_pin_oe,
	input wire logic        bus_out_oe,
	input wire logic        standby_active,
	input wire logic        sleep_active,
	input wire logic [15:0] module_halt
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// reset itself is the cause here, so this one is never disabled
	property p_halt_rst; disable iff (1'b0) !aresetn |=> module_halt == 16'h3FFF; endproperty
	a_halt_rst: assert property (p_halt_rst) else $error("stop bits wrong after reset");
	property p_hw_pin; hw_standby [*2] |-> !clock_pin_oe; endproperty
	a_hw_pin: assert property (p_hw_pin) else $error("clock pin driven in hw standby");
	property p_sby_pin; (standby_active && !hw_standby) [*2] |-> clock_pin_o && clock_pin_oe; endproperty
	a_sby_pin: assert property (p_sby_pin) else $error("clock pin not high in standby");
	property p_hw_bus; hw_standby [*2] |-> !bus_out_oe; endproperty
	a_hw_bus: assert property (p_hw_bus) else $error("bus driven in hw standby");
	property p_one_mode; !(standby_active && sleep_active); endproperty
	a_one_mode: assert property (p_one_mode) else $error("sleep and standby together");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer not held");
	// both halves are held one edge, the answer is registered on the next
	property p_b_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
	a_b_ans: assert property (p_b_ans) else $error("write answer late");
	property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_r_ans: assert property (p_r_ans) else $error("read answer late");
endmodule // pdcc_props

bind pdcc_top pdcc_props i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .hw_standby, .clock_pin_o, .clock_pin_oe, .bus_out_oe,
	.standby_active, .sleep_active, .module_halt);

// [verification/pdcc_partner.sv]
`timescale 1ns/1ps
// on-chip modules and the clock pin as seen from outside the block
module pdcc_partner (
	input wire logic        aclk,
	input wire logic        clock_pin_o,
	input wire logic        clock_pin_oe,
	input wire logic        chip_clock_en,
	input wire logic [15:0] module_halt,
	output logic            pin_level,
	output int              pin_edges,
	output logic [15:0]     module_live
);
	logic last_r = 1'b1;
	logic drv_r  = 1'b1;
	// floating pin
	// no pull on the pin: a released pin shows the inverse of its last driven level and stays there
	assign pin_level = clock_pin_oe ? clock_pin_o : ~drv_r;
	// count pin changes seen at each edge
	always_ff @(posedge aclk) begin
		last_r <= pin_level;
		if (clock_pin_oe)
			drv_r <= clock_pin_o;
		pin_edges <= pin_edges + ((pin_level !== last_r) ? 1 : 0);
	end
	// module clocking
	// a module runs only while its stop bit is clear and the chip clock ticks
	assign module_live = ~module_halt & {16{chip_clock_en}};
endmodule // pdcc_partner

// [verification/tb_power_down_clock_control.sv]
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb_power_down_clock_control;
	import pdcc_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_exec;
	logic        nmi_wake, hw_standby, cpu_clock_en, chip_clock_en, clock_pin_o, clock_pin_oe, pin_level;
	logic        bus_out_oe, bus_out_hold, standby_active, sleep_active;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_wstrb;
	logic [7:0]  irq_wake_n, sb, ck, hh, hl;
	logic [2:0]  mode_pins;
	logic [15:0] module_halt, module_live;
	int          n_errors = 0, n_checks = 0, cyc = 0, pin_edges, i, k, e0;
	// wait counts shortened for simulation
	localparam int SHORT_DIV = 1024;

	pdcc_top #(.WAIT_SHORT_DIV(SHORT_DIV)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.sleep_exec, .irq_wake_n, .nmi_wake, .hw_standby, .mode_pins, .cpu_clock_en, .chip_clock_en, .clock_pin_o,
		.clock_pin_oe, .bus_out_oe, .bus_out_hold, .standby_active, .sleep_active, .module_halt);
	pdcc_partner i_far (.aclk, .clock_pin_o, .clock_pin_oe, .chip_clock_en, .module_halt, .pin_level, .pin_edges,
		.module_live);

	////////////////////////////////////////////////////////////////
	// 25 MHz clock
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// hang guard: whole run needs well under this
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// write cycle: address and data offered together, each released once taken
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= {14'h0, a, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw_done && w_done));
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		`CHK("bresp", 2'b00, s_axi_bresp)
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= {14'h0, a, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		`CHK("rdata", {24'h0, e}, s_axi_rdata)
		`CHK("rresp", r, s_axi_rresp)
	endtask
	task automatic wsb(input logic w);
		for (k = 0; k < 100 && standby_active !== w; k++) @(posedge aclk);
		`CHK("standby", w, standby_active)
	endtask
	task automatic nap();
		@(posedge aclk);
		sleep_exec <= 1'b1;
		@(posedge aclk);
		sleep_exec <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h358C60CC;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{sleep_exec, nmi_wake, hw_standby, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hF;
		irq_wake_n = 8'hFF;
		mode_pins = 3'h5;
		{sb, ck, hh, hl} = {RST_STANDBY, RST_CLOCK, RST_HALT_HIGH, RST_HALT_LOW};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		mode_pins <= 3'(xs());
		// reset values, read-only mode status, unmapped place
		rd(IDX_STANDBY, sb, 2'b00);
		rd(IDX_CLOCK, ck, 2'b00);
		rd(IDX_HALT_HIGH, hh, 2'b00);
		rd(IDX_HALT_LOW, hl, 2'b00);
		wr(IDX_MODE, 8'h00);
		rd(IDX_MODE, {MODE_UPPER, mode_pins}, 2'b00);
		rd(16'h0100, 8'h00, 2'b10);
		$display("reset test done");
		for (i = 0; i < 3; i++) begin
			{hh, hl} = 16'(xs());
			wr(IDX_HALT_HIGH, hh);
			wr(IDX_HALT_LOW, hl);
			rd(IDX_HALT_HIGH, hh, 2'b00);
			rd(IDX_HALT_LOW, hl, 2'b00);
			`CHK("live", ~{hh, hl}, module_live)
		end
		$display("stop test done");
		// divide codes 0-5 at bus master scope and 0-3 at chip scope, counted over 64 cycles
		for (i = 0; i < 10; i++) begin
			ck = 8'((i < 6) ? i : (i - 6) | 8'h20);
			wr(IDX_CLOCK, ck);
			rd(IDX_CLOCK, ck, 2'b00);
			e0 = 0;
			repeat (64) @(posedge aclk) e0 += (i < 6) ? cpu_clock_en : chip_clock_en;
			`CHK("ticks", (i < 6) ? 64 >> i : 64 >> (i - 6), e0)
		end
		$display("divider test done");
		for (i = 0; i < 2; i++) begin
			wr(IDX_CLOCK, i ? 8'h80 : 8'h00);
			repeat (2) @(posedge aclk);
			e0 = pin_edges;
			repeat (4) @(posedge aclk);
			`CHK("pin edges", i ? 0 : 4, pin_edges - e0)
		end
		`CHK("pin", 1'b1, clock_pin_o)
		wr(IDX_CLOCK, 8'h00);
		nap();
		repeat (3) @(posedge aclk);
		`CHK("sleep", 1'b1, sleep_active)
		e0 = pin_edges;
		repeat (4) @(posedge aclk);
		`CHK("sleep pin", 4, pin_edges - e0)
		nmi_wake <= 1'b1;
		for (k = 0; k < 100 && sleep_active; k++) @(posedge aclk);
		nmi_wake <= 1'b0;
		`CHK("sleep", 1'b0, sleep_active)
		$display("sleep test done");
		// short wait, bus held, high irq ignored
		sb = 8'hF8;
		wr(IDX_STANDBY, sb);
		rd(IDX_STANDBY, sb, 2'b00);
		nap();
		wsb(1'b1);
		repeat (2) @(posedge aclk);
		`CHK("pin", 1'b1, clock_pin_o)
		`CHK("bus oe", 1'b1, bus_out_oe)
		`CHK("bus hold", 1'b1, bus_out_hold)
		irq_wake_n <= 8'hF7;
		repeat (10) @(posedge aclk);
		`CHK("standby", 1'b1, standby_active)
		irq_wake_n <= 8'hFE;
		wsb(1'b0);
		irq_wake_n <= 8'hFF;
		// float bus, high irq wakes, long settle seen
		sb = 8'h81;
		wr(IDX_STANDBY, sb);
		nap();
		wsb(1'b1);
		repeat (2) @(posedge aclk);
		`CHK("bus oe", 1'b0, bus_out_oe)
		irq_wake_n <= 8'h7F;
		// status read lands while settling; the rest of the wait is counted by wsb
		rd(IDX_POWER_STAT, 8'h02, 2'b00);
		wsb(1'b0);
		`CHK("settle", WAIT_0 / SHORT_DIV - 1, k)
		irq_wake_n <= 8'hFF;
		rd(IDX_POWER_STAT, 8'h00, 2'b00);
		// software sleep command enters the selected standby
		wr(IDX_POWER_CMD, 8'h01);
		wsb(1'b1);
		irq_wake_n <= 8'h7F;
		wsb(1'b0);
		irq_wake_n <= 8'hFF;
		$display("standby test done");
		hw_standby <= 1'b1;
		repeat (3) @(posedge aclk);
		`CHK("pin oe", 1'b0, clock_pin_oe)
		hw_standby <= 1'b0;
		repeat (3) @(posedge aclk);
		$display("hw standby test done");
		close_out();
	end
endmodule // tb_power_down_clock_control
